/* hdl/arb_pkg.sv */
// package: offsets, reset values and widths of the result register bank
`default_nettype none
package arb_pkg;
   localparam int unsigned NPAIR  = 15;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RES_W  = 16;

   // pair indexes
   localparam int unsigned P_GPIO6 = 0;
   localparam int unsigned P_GPIO7 = 1;
   localparam int unsigned P_GPIO8 = 2;
   localparam int unsigned P_DTMP1 = 3;
   localparam int unsigned P_DTMP2 = 4;
   localparam int unsigned P_CELL  = 5;
   localparam int unsigned P_AGPIO = 6;
   localparam int unsigned P_BAT   = 7;
   localparam int unsigned P_LOW_INTERNAL_REFERENCE  = 8;
   localparam int unsigned P_BG2   = 9;
   localparam int unsigned P_AVAO  = 10;
   localparam int unsigned P_AVDD  = 11;
   localparam int unsigned P_OVDAC = 12;
   localparam int unsigned P_UVDAC = 13;
   localparam int unsigned P_OTDAC = 14;

   localparam logic [ADDR_W-1:0] PAIR_HI_ADDR [NPAIR] = '{
      16'h0598, 16'h059a, 16'h059c, 16'h05ae, 16'h05b0,
      16'h05b2, 16'h05b4, 16'h05b6, 16'h05b8, 16'h05ba,
      16'h05be, 16'h05c0, 16'h05c2, 16'h05c4, 16'h05c6};
   localparam logic [ADDR_W-1:0] PAIR_LO_ADDR [NPAIR] = '{
      16'h0599, 16'h059b, 16'h059d, 16'h05af, 16'h05b1,
      16'h05b3, 16'h05b5, 16'h05b7, 16'h05b9, 16'h05bb,
      16'h05bf, 16'h05c1, 16'h05c3, 16'h05c5, 16'h05c7};

   // selector and status registers
   localparam logic [ADDR_W-1:0] CELL_SEL_ADDR  = 16'h05e0;
   localparam logic [ADDR_W-1:0] GPIO_SEL_ADDR  = 16'h05e1;
   localparam logic [ADDR_W-1:0] OT_SEL_ADDR    = 16'h05e2;
   localparam logic [ADDR_W-1:0] LOCK_LO_ADDR   = 16'h05e3;
   localparam logic [ADDR_W-1:0] LOCK_HI_ADDR   = 16'h05e4;
   localparam logic [ADDR_W-1:0] STATUS_ADDR    = 16'h05e5;

   localparam int unsigned CELL_SEL_W = 5;
   localparam int unsigned GPIO_SEL_W = 4;
   localparam int unsigned OT_SEL_BIT = 0;
   localparam int unsigned CELL_DEF_BIT = 0;
   localparam int unsigned LOCK_LO_CNT = 8;

   localparam logic [CELL_SEL_W-1:0] CELL_CHAN_FIRST = 5'h01;
   localparam logic [CELL_SEL_W-1:0] CELL_CHAN_LAST  = 5'h10;
   localparam logic [GPIO_SEL_W-1:0] GPIO_CHAN_FIRST = 4'h1;
   localparam logic [GPIO_SEL_W-1:0] GPIO_CHAN_LAST  = 4'h8;
   localparam logic [CELL_SEL_W-1:0] CELL_SEL_RST    = 5'h00;
   localparam logic [GPIO_SEL_W-1:0] GPIO_SEL_RST    = 4'h0;

   localparam logic [DATA_W-1:0] HI_RST  = 8'h80;
   localparam logic [DATA_W-1:0] LO_RST  = 8'h00;
   localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;
endpackage
`default_nettype wire

/* hdl/arb_result_bank.sv */
// result register bank with per-pair low byte freeze and selectors
// Operation
// - high byte read freezes low until read
// - gpio7 and gpio8 pairs, high at even
// - gpio6 low byte readable at own address
// - second cell result is two's complement pair
// - cell pair defined only for fixed channel
// - second gpio pair follows gpio selector
// - first die temperature pair from main converter
// - second die temperature pair from second converter
// - battery pin result in its own pair
// - low reference and bandgap each own pair
// - always-on and supply references own pairs
// - overvoltage dac pair holds converter reading
// - undervoltage dac pair holds converter reading
// - overtemp pair source chosen by select bit
`timescale 1ns/1ps
`default_nettype none

module arb_pair
   import arb_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire logic              upd,
   input  wire logic [RES_W-1:0]  upd_data,
   input  wire logic              rd_hi,
   input  wire logic              rd_lo,
   output logic      [DATA_W-1:0] hi_q,
   output logic      [DATA_W-1:0] lo_q,
   output logic                   held_q
);
   logic [DATA_W-1:0] hi_d;
   logic [DATA_W-1:0] lo_d;
   logic              held_d;

   always_comb begin
      hi_d   = hi_q;
      lo_d   = lo_q;
      held_d = held_q;
      if (upd) begin
         hi_d = upd_data[RES_W-1:DATA_W];
         // a high read in this cycle returns the old high, so keep low
         if (!held_q && !rd_hi) begin
            lo_d = upd_data[DATA_W-1:0];
         end
      end
      if (rd_hi) begin
         held_d = 1'b1;
      end else if (rd_lo) begin
         held_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hi_q   <= HI_RST;
         lo_q   <= LO_RST;
         held_q <= 1'b0;
      end else begin
         hi_q   <= hi_d;
         lo_q   <= lo_d;
         held_q <= held_d;
      end
   end

   lo_frozen_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      held_q |=> $stable(lo_q))
      else $error("low byte changed while held");

   hold_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rd_hi |=> held_q ##0 $stable(lo_q))
      else $error("high read did not freeze low byte");

   hold_release_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      held_q && rd_lo && !rd_hi |=> !held_q)
      else $error("low read did not release hold");

   newest_take_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !held_q && !rd_hi && upd
      |=> lo_q == $past(upd_data[DATA_W-1:0])
          && hi_q == $past(upd_data[RES_W-1:DATA_W]))
      else $error("free pair missed newest result");
endmodule

module arb_result_bank
   import arb_pkg::*;
(
   input  wire logic                         clk_sys,
   input  wire logic                         rstn,
   input  wire logic [ADDR_W-1:0]            reg_addr,
   input  wire logic [DATA_W-1:0]            reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [DATA_W-1:0]            reg_rdata,
   input  wire logic [NPAIR-1:0]             res_valid,
   input  wire logic [NPAIR-1:0][RES_W-1:0]  res_data,
   input  wire logic [CELL_SEL_W-1:0]        cell_chan,
   input  wire logic [GPIO_SEL_W-1:0]        gpio_chan,
   input  wire logic                         balancing_overtemperature_threshold_valid,
   input  wire logic [RES_W-1:0]             balancing_overtemperature_threshold_data,
   output logic      [CELL_SEL_W-1:0]        second_adc_cell_selector,
   output logic      [GPIO_SEL_W-1:0]        second_adc_gpio_selector,
   output logic                     overtemp_threshold_source_select,
   output logic                              cell_result_defined
);
   logic [CELL_SEL_W-1:0]       cell_sel_q;
   logic [CELL_SEL_W-1:0]       cell_sel_d;
   logic [GPIO_SEL_W-1:0]       gpio_sel_q;
   logic [GPIO_SEL_W-1:0]       gpio_sel_d;
   logic                        ot_sel_q;
   logic                        ot_sel_d;
   logic                        cell_def_q;
   logic                        cell_def_d;
   logic [DATA_W-1:0]           rdata_q;
   logic [DATA_W-1:0]           rdata_d;
   logic                        cell_fixed;
   logic                        gpio_fixed;
   logic                        cell_sel_wr;
   logic [NPAIR-1:0]            upd;
   logic [NPAIR-1:0][RES_W-1:0] upd_data;
   logic [NPAIR-1:0]            rd_hi;
   logic [NPAIR-1:0]            rd_lo;
   logic [NPAIR-1:0]            held;
   logic [DATA_W-1:0]           hi_vec [NPAIR];
   logic [DATA_W-1:0]           lo_vec [NPAIR];
   logic                        hit;

   assign second_adc_cell_selector         = cell_sel_q;
   assign second_adc_gpio_selector         = gpio_sel_q;
   assign overtemp_threshold_source_select = ot_sel_q;
   assign cell_result_defined              = cell_def_q;
   assign reg_rdata                        = rdata_q;

   assign cell_fixed = (cell_sel_q >= CELL_CHAN_FIRST)
                    && (cell_sel_q <= CELL_CHAN_LAST);
   assign gpio_fixed = (gpio_sel_q >= GPIO_CHAN_FIRST)
                    && (gpio_sel_q <= GPIO_CHAN_LAST);
   assign cell_sel_wr = reg_wr && (reg_addr == CELL_SEL_ADDR)
                     && (reg_wdata[CELL_SEL_W-1:0] != cell_sel_q);

   // update gating per source
   always_comb begin
      upd      = res_valid;
      upd_data = res_data;
      // cell result kept only from the fixed channel
      upd[P_CELL] = res_valid[P_CELL] && cell_fixed
                 && (cell_chan == cell_sel_q);
      // second converter gpio result only from the selected gpio
      upd[P_AGPIO] = res_valid[P_AGPIO] && gpio_fixed
                  && (gpio_chan == gpio_sel_q);
      // overtemp dac pair: normal or balancing threshold
      if (ot_sel_q) begin
         upd[P_OTDAC]      = balancing_overtemperature_threshold_valid;
         upd_data[P_OTDAC] = balancing_overtemperature_threshold_data;
      end else begin
         upd[P_OTDAC]      = res_valid[P_OTDAC];
         upd_data[P_OTDAC] = res_data[P_OTDAC];
      end
   end

   // each pair decodes its own high and low offsets
   genvar gi;
   generate
      for (gi = 0; gi < NPAIR; gi++) begin : g_pair
         assign rd_hi[gi] = reg_rd && (reg_addr == PAIR_HI_ADDR[gi]);
         assign rd_lo[gi] = reg_rd && (reg_addr == PAIR_LO_ADDR[gi]);
         arb_pair u_pair (
            .clk_sys  (clk_sys),
            .rstn     (rstn),
            .upd      (upd[gi]),
            .upd_data (upd_data[gi]),
            .rd_hi    (rd_hi[gi]),
            .rd_lo    (rd_lo[gi]),
            .hi_q     (hi_vec[gi]),
            .lo_q     (lo_vec[gi]),
            .held_q   (held[gi])
         );
      end
   endgenerate

   // selector registers; result offsets take no write
   always_comb begin
      cell_sel_d = cell_sel_q;
      gpio_sel_d = gpio_sel_q;
      ot_sel_d   = ot_sel_q;
      cell_def_d = cell_def_q;
      if (reg_wr) begin
         case (reg_addr)
            CELL_SEL_ADDR: begin
               cell_sel_d = reg_wdata[CELL_SEL_W-1:0];
            end
            GPIO_SEL_ADDR: begin
               gpio_sel_d = reg_wdata[GPIO_SEL_W-1:0];
            end
            OT_SEL_ADDR: begin
               ot_sel_d = reg_wdata[OT_SEL_BIT];
            end
            default: begin
               ot_sel_d = ot_sel_q;
            end
         endcase
      end
      // a sample of the old channel must not mark the new one defined
      if (cell_sel_wr) begin
         cell_def_d = 1'b0;
      end else if (upd[P_CELL]) begin
         cell_def_d = 1'b1;
      end
   end

   // read data, one cycle after the strobe, zero otherwise
   always_comb begin
      rdata_d = RD_ZERO;
      hit     = 1'b0;
      if (reg_rd) begin
         for (int i = 0; i < NPAIR; i++) begin
            if (reg_addr == PAIR_HI_ADDR[i]) begin
               rdata_d = hi_vec[i];
               hit     = 1'b1;
            end
            if (reg_addr == PAIR_LO_ADDR[i]) begin
               rdata_d = lo_vec[i];
               hit     = 1'b1;
            end
         end
         case (reg_addr)
            CELL_SEL_ADDR: begin
               rdata_d[CELL_SEL_W-1:0] = cell_sel_q;
            end
            GPIO_SEL_ADDR: begin
               rdata_d[GPIO_SEL_W-1:0] = gpio_sel_q;
            end
            OT_SEL_ADDR: begin
               rdata_d[OT_SEL_BIT] = ot_sel_q;
            end
            LOCK_LO_ADDR: begin
               rdata_d = held[LOCK_LO_CNT-1:0];
            end
            LOCK_HI_ADDR: begin
               rdata_d[NPAIR-LOCK_LO_CNT-1:0] = held[NPAIR-1:LOCK_LO_CNT];
            end
            STATUS_ADDR: begin
               rdata_d[CELL_DEF_BIT] = cell_def_q;
            end
            default: begin
               hit = hit;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cell_sel_q <= CELL_SEL_RST;
         gpio_sel_q <= GPIO_SEL_RST;
         ot_sel_q   <= 1'b0;
         cell_def_q <= 1'b0;
         rdata_q    <= RD_ZERO;
      end else begin
         cell_sel_q <= cell_sel_d;
         gpio_sel_q <= gpio_sel_d;
         ot_sel_q   <= ot_sel_d;
         cell_def_q <= cell_def_d;
         rdata_q    <= rdata_d;
      end
   end

   write_ignored_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      reg_wr && !(|upd) |=> $stable(held)
         && hi_vec[P_BAT] == $past(hi_vec[P_BAT])
         && lo_vec[P_GPIO6] == $past(lo_vec[P_GPIO6]))
      else $error("write changed a result register");

   main_gpio7_result_hi_read_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      reg_rd && reg_addr == PAIR_HI_ADDR[P_GPIO7]
      |=> reg_rdata == $past(hi_vec[P_GPIO7]))
      else $error("gpio7 high byte read wrong");

   gpio8_pair_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      reg_rd && reg_addr == PAIR_LO_ADDR[P_GPIO8]
      |=> reg_rdata == $past(lo_vec[P_GPIO8]))
      else $error("gpio8 low byte read wrong");

   main_gpio6_result_lo_read_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      reg_rd && reg_addr == PAIR_LO_ADDR[P_GPIO6]
      |=> reg_rdata == $past(lo_vec[P_GPIO6]))
      else $error("gpio6 low byte read wrong");

   cell_gate_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !(res_valid[P_CELL] && cell_fixed && cell_chan == cell_sel_q)
      |=> $stable(hi_vec[P_CELL]))
      else $error("cell pair took an unselected sample");

   cell_defined_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      upd[P_CELL] && !cell_sel_wr |=> cell_result_defined
      ##0 hi_vec[P_CELL] == $past(res_data[P_CELL][RES_W-1:DATA_W]))
      else $error("cell pair not marked defined");

   gpio_gate_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_AGPIO] && gpio_chan != gpio_sel_q
      |=> $stable(hi_vec[P_AGPIO]))
      else $error("gpio pair took an unselected sample");

   ot_source_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      ot_sel_q && balancing_overtemperature_threshold_valid
      |=> hi_vec[P_OTDAC] == $past(balancing_overtemperature_threshold_data[RES_W-1:DATA_W]))
      else $error("overtemp pair ignored balancing source");

   ot_normal_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      !ot_sel_q && !res_valid[P_OTDAC] |=> $stable(hi_vec[P_OTDAC]))
      else $error("overtemp pair took balancing source");

   bat_update_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_BAT]
      |=> hi_vec[P_BAT] == $past(res_data[P_BAT][RES_W-1:DATA_W]))
      else $error("battery pair missed update");

   temp_main_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_DTMP1] && !held[P_DTMP1] && !rd_hi[P_DTMP1]
      |=> lo_vec[P_DTMP1] == $past(res_data[P_DTMP1][DATA_W-1:0]))
      else $error("die temperature low byte missed update");

   temp_second_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_DTMP2]
      |=> hi_vec[P_DTMP2] == $past(res_data[P_DTMP2][RES_W-1:DATA_W]))
      else $error("second die temperature pair missed update");

   low_ref_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_LOW_INTERNAL_REFERENCE]
      |=> hi_vec[P_LOW_INTERNAL_REFERENCE] == $past(res_data[P_LOW_INTERNAL_REFERENCE][RES_W-1:DATA_W]))
      else $error("low reference pair missed update");

   bandgap_two_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_BG2]
      |=> hi_vec[P_BG2] == $past(res_data[P_BG2][RES_W-1:DATA_W]))
      else $error("bandgap pair missed update");

   always_on_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_AVAO]
      |=> hi_vec[P_AVAO] == $past(res_data[P_AVAO][RES_W-1:DATA_W]))
      else $error("always-on reference pair missed update");

   supply_ref_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_AVDD]
      |=> hi_vec[P_AVDD] == $past(res_data[P_AVDD][RES_W-1:DATA_W]))
      else $error("supply reference pair missed update");

   ov_dac_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_OVDAC]
      |=> hi_vec[P_OVDAC] == $past(res_data[P_OVDAC][RES_W-1:DATA_W]))
      else $error("overvoltage dac pair missed update");

   uv_dac_a: assert property (
      @(posedge clk_sys) disable iff (!rstn)
      res_valid[P_UVDAC]
      |=> hi_vec[P_UVDAC] == $past(res_data[P_UVDAC][RES_W-1:DATA_W]))
      else $error("undervoltage dac pair missed update");

   rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !reg_rd || !hit && reg_addr < CELL_SEL_ADDR |=> reg_rdata == RD_ZERO)
      else $error("read data not zero outside a read");
endmodule

`default_nettype wire

/* verification/tb.sv */
// self-checking testbench for the result register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
   import arb_pkg::*;

   logic                            clk_sys    = 1'b0;
   logic                            rstn       = 1'b0;
   logic [ADDR_W-1:0]               reg_addr   = '0;
   logic [DATA_W-1:0]               reg_wdata  = '0;
   logic                            reg_wr     = 1'b0;
   logic                            reg_rd     = 1'b0;
   logic [DATA_W-1:0]               reg_rdata;
   logic [NPAIR-1:0]                res_valid  = '0;
   logic [NPAIR-1:0][RES_W-1:0]     res_data   = '0;
   logic [CELL_SEL_W-1:0]           cell_chan  = 5'h03;
   logic [GPIO_SEL_W-1:0]           gpio_chan  = 4'h2;
   logic                            balancing_overtemperature_threshold_valid = 1'b0;
   logic [RES_W-1:0]                balancing_overtemperature_threshold_data  = '0;
   logic [CELL_SEL_W-1:0]           cell_sel;
   logic [GPIO_SEL_W-1:0]           gpio_sel;
   logic                            ot_sel;
   logic                            cell_def;
   int                              fails = 0;
   int                              total_checks = 0;

   always #2.5 clk_sys = ~clk_sys;

   arb_result_bank dut (
      .clk_sys                          (clk_sys),
      .rstn                             (rstn),
      .reg_addr                         (reg_addr),
      .reg_wdata                        (reg_wdata),
      .reg_wr                           (reg_wr),
      .reg_rd                           (reg_rd),
      .reg_rdata                        (reg_rdata),
      .res_valid                        (res_valid),
      .res_data                         (res_data),
      .cell_chan                        (cell_chan),
      .gpio_chan                        (gpio_chan),
      .balancing_overtemperature_threshold_valid                       (balancing_overtemperature_threshold_valid),
      .balancing_overtemperature_threshold_data                        (balancing_overtemperature_threshold_data),
      .second_adc_cell_selector         (cell_sel),
      .second_adc_gpio_selector         (gpio_sel),
      .overtemp_threshold_source_select (ot_sel),
      .cell_result_defined              (cell_def)
   );

   task automatic results();
      if (fails == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      @(negedge clk_sys);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      @(negedge clk_sys);
      chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
   endtask

   // index 15 drives the balancing overtemp source
   task automatic upd(input int i, input logic [15:0] d);
      @(posedge clk_sys);
      if (i == 15) begin
         balancing_overtemperature_threshold_valid <= 1'b1;
         balancing_overtemperature_threshold_data  <= d;
      end else begin
         res_valid[i] <= 1'b1;
         res_data[i]  <= d;
      end
      @(posedge clk_sys);
      res_valid  <= '0;
      balancing_overtemperature_threshold_valid <= 1'b0;
   endtask

   task automatic pchk(input int i, input logic [15:0] e);
      rd(PAIR_HI_ADDR[i], e[15:8]);
      rd(PAIR_LO_ADDR[i], e[7:0]);
   endtask

   initial begin
      #100000;
      fails++;
      results();
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      @(negedge clk_sys);
      chk("selectors", 16'h0000, {6'h00, cell_sel, gpio_sel, ot_sel});
      chk("cell defined", 16'h0000, {15'h0000, cell_def});
      for (int i = 0; i < NPAIR; i++) pchk(i, 16'h8000);
      wr(CELL_SEL_ADDR, 8'h03);
      wr(GPIO_SEL_ADDR, 8'h02);
      rd(CELL_SEL_ADDR, 8'h03);
      rd(GPIO_SEL_ADDR, 8'h02);
      chk("selectors", 16'h0064, {6'h00, cell_sel, gpio_sel, ot_sel});
      for (int i = 0; i < NPAIR; i++) upd(i, {8'(8'h10 + i), 8'(8'ha0 + i)});
      for (int i = 0; i < NPAIR; i++) begin
         pchk(i, {8'(8'h10 + i), 8'(8'ha0 + i)});
      end
      chk("cell defined", 16'h0001, {15'h0000, cell_def});
      rd(STATUS_ADDR, 8'h01);
      pchk(12, 16'h1cac);
      pchk(13, 16'h1dad);
      upd(5, 16'hfe0c);
      pchk(5, 16'hfe0c);
      @(posedge clk_sys);
      cell_chan <= 5'h04;
      upd(5, 16'h1111);
      pchk(5, 16'hfe0c);
      wr(CELL_SEL_ADDR, 8'h00);
      chk("cell defined", 16'h0000, {15'h0000, cell_def});
      @(posedge clk_sys);
      cell_chan <= 5'h00;
      upd(5, 16'h2222);
      pchk(5, 16'hfe0c);
      wr(CELL_SEL_ADDR, 8'h10);
      @(posedge clk_sys);
      cell_chan <= 5'h10;
      upd(5, 16'h3333);
      pchk(5, 16'h3333);
      @(posedge clk_sys);
      gpio_chan <= 4'h5;
      upd(6, 16'h4444);
      pchk(6, 16'h16a6);
      wr(GPIO_SEL_ADDR, 8'h05);
      upd(6, 16'h4545);
      pchk(6, 16'h4545);
      upd(15, 16'h7777);
      pchk(14, 16'h1eae);
      wr(OT_SEL_ADDR, 8'h01);
      chk("ot select", 16'h0001, {15'h0000, ot_sel});
      upd(15, 16'h7788);
      upd(14, 16'h9999);
      pchk(14, 16'h7788);
      upd(1, 16'h1122);
      rd(PAIR_HI_ADDR[1], 8'h11);
      rd(LOCK_LO_ADDR, 8'h02);
      rd(LOCK_HI_ADDR, 8'h00);
      upd(1, 16'h3344);
      rd(PAIR_HI_ADDR[1], 8'h33);
      rd(PAIR_LO_ADDR[1], 8'h22);
      rd(PAIR_LO_ADDR[1], 8'h22);
      rd(LOCK_LO_ADDR, 8'h00);
      upd(1, 16'h5566);
      rd(PAIR_LO_ADDR[1], 8'h66);
      wr(PAIR_HI_ADDR[7], 8'hff);
      wr(PAIR_LO_ADDR[7], 8'hff);
      wr(LOCK_LO_ADDR, 8'hff);
      rd(LOCK_LO_ADDR, 8'h00);
      pchk(7, 16'h17a7);
      rd(16'h0600, 8'h00);
      @(negedge clk_sys);
      chk("idle rdata", 16'h0000, {8'h00, reg_rdata});
      results();
   end
endmodule

`default_nettype wire
